// *** hdl/cwv_regs.sv ***
// Verb decoder and storage for the microphone and selector nodes
//
// Behaviour
// - Microphone node answers at 0x18, selector node at 0x19.
// - Microphone widget type reads 4h when digital microphone enabled, else Fh.
// - Microphone capability word has only stereo bit set.
// - Microphone bitexact stream flag reads zero.
// - Both nodes report zero sample delay.
// - Microphone terminal capabilities show only input-capable bit 5.
// - Input path enable bit 5 read by F07, written by 707, resets 0.
// - Set verbs take an 8-bit payload and answer all zeros.
// - Terminal defaults read by F1C with documented reset fields.
// - Misc bit 0 of terminal defaults is jack detect override.
// - Selector reports type 3 with list, own gain, output gain, stereo.
// - Selector gain capabilities: no mute, increment 0x27, count 0x04.
// - Selector gain offset field reads zero.
// - Each gain channel is a 3-bit step code resetting to 0.
// - Right gain B80/390, left gain BA0/3A0, stored independently.
// - Source choice 3-bit index via F01/701, resets to 0.
// - Source list length 7, short form, wide flag cleared.
// - F02 payload 00/04 return the two fixed halves of the list.
`timescale 1ns/1ps
module cwv_regs
	import cwv_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        link_clk,
	input  wire logic        link_rst,
	input  wire logic        verb_valid,
	input  wire logic [7:0]  verb_node,
	input  wire logic [11:0] verb_id,
	input  wire logic [7:0]  verb_payload,
	output logic             resp_valid,
	output logic [31:0]      resp_data,
	input  wire logic        digital_microphone_enable,
	output logic             input_path_enable,
	output logic             jack_detect_override,
	output logic [2:0]       right_output_gain,
	output logic [2:0]       left_output_gain,
	output logic [2:0]       source_choice
);
	// ==========================================================
	// Link side: capture verb, respond when answer returns
	logic        req_tog_evt;
	logic [7:0]  cap_node;
	logic [11:0] cap_id;
	logic [7:0]  cap_pay;
	logic        busy;
	logic        done_evt;
	logic [31:0] answer;

	// Verb fields held stable while the request crosses
	always_ff @(posedge link_clk or posedge link_rst) begin
		if (link_rst) begin
			cap_node <= 8'h00;
			cap_id   <= 12'h000;
			cap_pay  <= 8'h00;
		end else if (verb_valid && !busy) begin
			cap_node <= verb_node;
			cap_id   <= verb_id;
			cap_pay  <= verb_payload;
		end
	end

	// Verbs arriving while busy are dropped; link spacing avoids that
	always_ff @(posedge link_clk or posedge link_rst) begin
		if (link_rst)
			busy <= 1'b0;
		else if (verb_valid && !busy)
			busy <= 1'b1;
		else if (done_evt)
			busy <= 1'b0;
	end

	assign req_tog_evt = verb_valid && !busy;

	always_ff @(posedge link_clk or posedge link_rst) begin
		if (link_rst) begin
			resp_valid <= 1'b0;
			resp_data  <= 32'h0000_0000;
		end else begin
			resp_valid <= done_evt;
			if (done_evt)
				resp_data <= answer;
		end
	end

	// ==========================================================
	// Crossings
	logic req_evt;
	logic ans_evt;
	logic digital_microphone_en;

	cwv_toggle u_req (
		.src_clk   (link_clk),
		.src_rst   (link_rst),
		.src_pulse (req_tog_evt),
		.dst_clk   (clk),
		.dst_rst   (sys_rst),
		.dst_pulse (req_evt)
	);

	cwv_toggle u_ans (
		.src_clk   (clk),
		.src_rst   (sys_rst),
		.src_pulse (ans_evt),
		.dst_clk   (link_clk),
		.dst_rst   (link_rst),
		.dst_pulse (done_evt)
	);

	cwv_sync #(.WIDTH(1)) u_digital_microphone (
		.clk (clk),
		.rst (sys_rst),
		.d   (digital_microphone_enable),
		.q   (digital_microphone_en)
	);

	// ==========================================================
	// Core side decode
	logic        is_mic;
	logic        is_sel;
	logic [31:0] term_defaults;
	logic [31:0] next_answer;

	assign is_mic = (cap_node == NODE_MIC1);
	assign is_sel = (cap_node == NODE_SEL0);

	function automatic logic [31:0] low3(input logic [2:0] v);
		return {29'h0000_0000, v};
	endfunction : low3

	always_comb begin
		next_answer = 32'h0000_0000;
		if (is_mic) begin
			unique case (cap_id)
				VERB_GET_PARAM: begin
					if (cap_pay == PAR_WIDGET_CAP)
						next_answer = MIC_WIDGET_CAPABILITIES_BASE |
							({28'h000_0000, digital_microphone_en ? TYPE_PIN : TYPE_VENDOR} << TYPE_LSB);
					else if (cap_pay == PAR_TERM_CAP)
						next_answer = MIC_TERM_CAP;
				end
				VERB_GET_CTL: next_answer = {26'h000_0000, input_path_enable, 5'h00};
				VERB_GET_DEF: next_answer = term_defaults;
				default: next_answer = 32'h0000_0000;
			endcase
		end else if (is_sel) begin
			unique case (cap_id)
				VERB_GET_PARAM: begin
					if (cap_pay == PAR_WIDGET_CAP)
						next_answer = SEL_WIDGET_CAPABILITIES;
					else if (cap_pay == PAR_GAIN_CAP)
						next_answer = SEL_GAIN_CAP;
					else if (cap_pay == PAR_LIST_LEN)
						next_answer = SEL_LIST_LEN;
				end
				VERB_GET_GAIN_R: next_answer = low3(right_output_gain);
				VERB_GET_GAIN_L: next_answer = low3(left_output_gain);
				VERB_GET_SRC:    next_answer = low3(source_choice);
				VERB_GET_LIST: begin
					if (cap_pay == LIST_LOW_IDX)
						next_answer = SEL_LIST_LOW;
					else if (cap_pay == LIST_HIGH_IDX)
						next_answer = SEL_LIST_HIGH;
				end
				default: next_answer = 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// Stored fields; fields read from link registers stable during crossing
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			input_path_enable <= 1'b0;
		else if (req_evt && is_mic && cap_id == VERB_SET_CTL)
			input_path_enable <= cap_pay[IN_EN_BIT];
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			term_defaults <= DEF_RESET;
		else if (req_evt && is_mic) begin
			unique case (cap_id)
				VERB_SET_DEF0: term_defaults[7:0]   <= cap_pay;
				VERB_SET_DEF1: term_defaults[15:8]  <= cap_pay;
				VERB_SET_DEF2: term_defaults[23:16] <= cap_pay;
				VERB_SET_DEF3: term_defaults[31:24] <= cap_pay;
				default: term_defaults <= term_defaults;
			endcase
		end
	end

	assign jack_detect_override = term_defaults[JACK_OVR_BIT];

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			right_output_gain <= GAIN_RESET;
			left_output_gain  <= GAIN_RESET;
		end else if (req_evt && is_sel) begin
			if (cap_id == VERB_SET_GAIN_R)
				right_output_gain <= cap_pay[2:0];
			if (cap_id == VERB_SET_GAIN_L)
				left_output_gain <= cap_pay[2:0];
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			source_choice <= SRC_RESET;
		else if (req_evt && is_sel && cap_id == VERB_SET_SRC)
			source_choice <= cap_pay[2:0];
	end

	// Answer word captured in core domain, stable until next request
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			answer <= 32'h0000_0000;
		else if (req_evt)
			answer <= next_answer;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			ans_evt <= 1'b0;
		else
			ans_evt <= req_evt;
	end

	// ==========================================================
	// Checks
	gain_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		!(req_evt && is_sel && cap_id == VERB_SET_GAIN_L) |=> $stable(left_output_gain))
		else $error("left gain changed without its verb");
	gain_write_a: assert property (@(posedge clk) disable iff (sys_rst)
		req_evt && is_sel && cap_id == VERB_SET_GAIN_L |=> left_output_gain == $past(cap_pay[2:0]))
		else $error("left gain not written");
	set_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
		req_evt && cap_id == VERB_SET_SRC |=> answer == 32'h0000_0000)
		else $error("set verb answer not zero");
	input_path_enable_write_a: assert property (@(posedge clk) disable iff (sys_rst)
		req_evt && is_mic && cap_id == VERB_SET_CTL |=> input_path_enable == $past(cap_pay[5]))
		else $error("input enable not written");
	mic_type_a: assert property (@(posedge clk) disable iff (sys_rst)
		req_evt && is_mic && cap_id == VERB_GET_PARAM && cap_pay == PAR_WIDGET_CAP
		|=> answer[23:20] == ($past(digital_microphone_en) ? 4'h4 : 4'hF) && answer[19:0] == 20'h0_0001)
		else $error("mic widget word wrong");
	list_hi_a: assert property (@(posedge clk) disable iff (sys_rst)
		req_evt && is_sel && cap_id == VERB_GET_LIST && cap_pay == 8'h04
		|=> answer == 32'h000A_0D0C)
		else $error("high list wrong");
	src_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		!(req_evt && is_sel && cap_id == VERB_SET_SRC) |=> $stable(source_choice))
		else $error("source choice changed spuriously");
	ans_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
		req_evt |=> ans_evt ##1 !ans_evt)
		else $error("answer event not a single pulse");
	resp_once_a: assert property (@(posedge link_clk) disable iff (link_rst)
		resp_valid |=> !resp_valid)
		else $error("response valid longer than one cycle");
	resp_idle_a: assert property (@(posedge link_clk) disable iff (link_rst)
		resp_valid |-> !busy)
		else $error("response while still busy");
	cap_hold_a: assert property (@(posedge link_clk) disable iff (link_rst)
		busy |=> $stable(cap_node) && $stable(cap_id) && $stable(cap_pay))
		else $error("verb fields moved while crossing");
	resp_keep_a: assert property (@(posedge link_clk) disable iff (link_rst)
		!done_evt |=> $stable(resp_data))
		else $error("response word moved between answers");
	// Bound covers both synchronisers plus the two core cycles
	resp_due_a: assert property (@(posedge link_clk) disable iff (link_rst)
		req_tog_evt |-> ##[2:8] resp_valid)
		else $error("verb taken but not answered in time");

	// ==========================================================
	// Stored-field checks
	right_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		!(req_evt && is_sel && cap_id == VERB_SET_GAIN_R) |=> $stable(right_output_gain))
		else $error("right gain changed without its verb");
	right_write_a: assert property (@(posedge clk) disable iff (sys_rst)
		req_evt && is_sel && cap_id == VERB_SET_GAIN_R
		|=> right_output_gain == $past(cap_pay[2:0]))
		else $error("right gain not written");
	src_write_a: assert property (@(posedge clk) disable iff (sys_rst)
		req_evt && is_sel && cap_id == VERB_SET_SRC
		|=> source_choice == $past(cap_pay[2:0]))
		else $error("source choice not written");
	input_path_enable_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		!(req_evt && is_mic && cap_id == VERB_SET_CTL) |=> $stable(input_path_enable))
		else $error("input enable changed without its verb");
	def_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		!(req_evt && is_mic) |=> $stable(term_defaults))
		else $error("terminal defaults changed without a verb");
	def_low_a: assert property (@(posedge clk) disable iff (sys_rst)
		req_evt && is_mic && cap_id == VERB_SET_DEF0
		|=> term_defaults == {$past(term_defaults[31:8]), $past(cap_pay)})
		else $error("terminal defaults byte 0 write wrong");
	def_high_a: assert property (@(posedge clk) disable iff (sys_rst)
		req_evt && is_mic && cap_id == VERB_SET_DEF3
		|=> term_defaults == {$past(cap_pay), $past(term_defaults[23:0])})
		else $error("terminal defaults byte 3 write wrong");

	// ==========================================================
	// Answer-word checks
	other_node_a: assert property (@(posedge clk) disable iff (sys_rst)
		req_evt && !is_mic && !is_sel |=> answer == 32'h0000_0000)
		else $error("foreign node answered");
	// Every set verb carries 7h or 3h in its top nibble
	set_answer_a: assert property (@(posedge clk) disable iff (sys_rst)
		req_evt && (cap_id[11:8] == 4'h7 || cap_id[11:8] == 4'h3) |=> answer == 32'h0000_0000)
		else $error("set verb answered nonzero");
	mic_term_a: assert property (@(posedge clk) disable iff (sys_rst)
		req_evt && is_mic && cap_id == VERB_GET_PARAM && cap_pay == 8'h0C
		|=> answer == 32'h0000_0020)
		else $error("mic terminal capabilities wrong");
	ctl_read_a: assert property (@(posedge clk) disable iff (sys_rst)
		req_evt && is_mic && cap_id == VERB_GET_CTL
		|=> answer == {26'h000_0000, $past(input_path_enable), 5'h00})
		else $error("terminal control read wrong");
	sel_widget_capabilities_a: assert property (@(posedge clk) disable iff (sys_rst)
		req_evt && is_sel && cap_id == VERB_GET_PARAM && cap_pay == 8'h09
		|=> answer == 32'h0030_010D)
		else $error("selector widget word wrong");
	gain_cap_a: assert property (@(posedge clk) disable iff (sys_rst)
		req_evt && is_sel && cap_id == VERB_GET_PARAM && cap_pay == 8'h12
		|=> answer == 32'h0027_0400)
		else $error("gain capabilities wrong");
	list_len_a: assert property (@(posedge clk) disable iff (sys_rst)
		req_evt && is_sel && cap_id == VERB_GET_PARAM && cap_pay == 8'h0E
		|=> answer == 32'h0000_0007)
		else $error("source list length wrong");
	list_lo_a: assert property (@(posedge clk) disable iff (sys_rst)
		req_evt && is_sel && cap_id == VERB_GET_LIST && cap_pay == 8'h00
		|=> answer == 32'h0B0F_160E)
		else $error("low list wrong");
	gain_read_a: assert property (@(posedge clk) disable iff (sys_rst)
		req_evt && is_sel && cap_id == VERB_GET_GAIN_L
		|=> answer == {29'h000_0000, $past(left_output_gain)})
		else $error("left gain read wrong");
endmodule : cwv_regs

// *** hdl/cwv_pkg.sv ***
// Package: verb codes, node numbers, field layouts and reset values
package cwv_pkg;
	// ==========================================================
	// Node numbers and verb identifiers
	localparam logic [7:0]  NODE_MIC1       = 8'h18;
	localparam logic [7:0]  NODE_SEL0       = 8'h19;
	localparam logic [11:0] VERB_GET_PARAM  = 12'h0F00;
	localparam logic [11:0] VERB_GET_CTL    = 12'h0F07;
	localparam logic [11:0] VERB_SET_CTL    = 12'h0707;
	localparam logic [11:0] VERB_GET_DEF    = 12'h0F1C;
	localparam logic [11:0] VERB_SET_DEF0   = 12'h071C;
	localparam logic [11:0] VERB_SET_DEF1   = 12'h071D;
	localparam logic [11:0] VERB_SET_DEF2   = 12'h071E;
	localparam logic [11:0] VERB_SET_DEF3   = 12'h071F;
	localparam logic [11:0] VERB_GET_GAIN_R = 12'h0B80;
	localparam logic [11:0] VERB_SET_GAIN_R = 12'h0390;
	localparam logic [11:0] VERB_GET_GAIN_L = 12'h0BA0;
	localparam logic [11:0] VERB_SET_GAIN_L = 12'h03A0;
	localparam logic [11:0] VERB_GET_SRC    = 12'h0F01;
	localparam logic [11:0] VERB_SET_SRC    = 12'h0701;
	localparam logic [11:0] VERB_GET_LIST   = 12'h0F02;
	// ==========================================================
	// Parameter payloads
	localparam logic [7:0]  PAR_WIDGET_CAP  = 8'h09;
	localparam logic [7:0]  PAR_TERM_CAP    = 8'h0C;
	localparam logic [7:0]  PAR_LIST_LEN    = 8'h0E;
	localparam logic [7:0]  PAR_GAIN_CAP    = 8'h12;
	localparam logic [7:0]  LIST_LOW_IDX    = 8'h00;
	localparam logic [7:0]  LIST_HIGH_IDX   = 8'h04;
	// ==========================================================
	// Constant words and field positions
	localparam logic [3:0]  TYPE_PIN        = 4'h4;
	localparam logic [3:0]  TYPE_VENDOR     = 4'hF;
	localparam int          TYPE_LSB        = 20;
	localparam logic [31:0] MIC_WIDGET_CAPABILITIES_BASE   = 32'h0000_0001;
	localparam logic [31:0] MIC_TERM_CAP    = 32'h0000_0020;
	localparam logic [31:0] SEL_WIDGET_CAPABILITIES        = 32'h0030_010D;
	localparam logic [31:0] SEL_GAIN_CAP    = 32'h0027_0400;
	localparam logic [31:0] SEL_LIST_LEN    = 32'h0000_0007;
	localparam logic [31:0] SEL_LIST_LOW    = 32'h0B0F_160E;
	localparam logic [31:0] SEL_LIST_HIGH   = 32'h000A_0D0C;
	localparam int          IN_EN_BIT       = 5;
	localparam int          JACK_OVR_BIT    = 8;
	localparam logic [31:0] DEF_RESET       = 32'h50A0_00F0;
	localparam logic [2:0]  GAIN_RESET      = 3'h0;
	localparam logic [2:0]  SRC_RESET       = 3'h0;
endpackage : cwv_pkg

// *** hdl/cwv_sync.sv ***
// Two-flop level synchroniser
`timescale 1ns/1ps
module cwv_sync
	import cwv_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	// Zero width would leave the crossing with no path at all
	if (WIDTH < 1) begin : g_width_chk
		$error("synchroniser width must be at least one");
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : cwv_sync

// *** hdl/cwv_toggle.sv ***
// Toggle-based event crossing between two clocks
`timescale 1ns/1ps
module cwv_toggle
	import cwv_pkg::*;
(
	input  wire logic src_clk,
	input  wire logic src_rst,
	input  wire logic src_pulse,
	input  wire logic dst_clk,
	input  wire logic dst_rst,
	output logic      dst_pulse
);
	logic tog;
	logic tog_s;
	logic tog_d;

	always_ff @(posedge src_clk or posedge src_rst) begin
		if (src_rst)
			tog <= 1'b0;
		else if (src_pulse)
			tog <= ~tog;
	end

	cwv_sync #(.WIDTH(1)) u_sync (
		.clk (dst_clk),
		.rst (dst_rst),
		.d   (tog),
		.q   (tog_s)
	);

	always_ff @(posedge dst_clk or posedge dst_rst) begin
		if (dst_rst)
			tog_d <= 1'b0;
		else
			tog_d <= tog_s;
	end

	assign dst_pulse = tog_s ^ tog_d;
endmodule : cwv_toggle

// *** sim/cwv_host.sv ***
// Host controller model: issues one verb at a time and collects its answer
`timescale 1ns/1ps
module cwv_host (
	output logic             verb_valid,
	output logic [7:0]       verb_node,
	output logic [11:0]      verb_id,
	output logic [7:0]       verb_payload,
	input  wire logic        link_clk,
	input  wire logic        resp_valid,
	input  wire logic [31:0] resp_data
);
	initial begin
		verb_valid = 1'b0;
		verb_node = 8'h00;
		verb_id = 12'h000;
		verb_payload = 8'h00;
	end
	// ==========================================================
	// One transfer; idle adds link cycles to play a slow host
	task automatic xfer(input logic [7:0] node, input logic [11:0] id,
		input logic [7:0] pay, input int idle, output logic [31:0] rsp, output bit ok);
		ok = 1'b0;
		rsp = 32'h0000_0000;
		// Extra cycle keeps the gap after the previous answer
		repeat (idle + 1) @(negedge link_clk);
		verb_valid = 1'b1;
		verb_node = node;
		verb_id = id;
		verb_payload = pay;
		@(negedge link_clk);
		// Released fields carry garbage, never the old verb
		verb_valid = 1'b0;
		verb_node = ~node;
		verb_id = ~id;
		verb_payload = ~pay;
		for (int i = 0; i < 12 && !ok; i++) begin
			@(negedge link_clk);
			if (resp_valid === 1'b1) begin
				rsp = resp_data;
				ok = 1'b1;
			end
		end
	endtask : xfer
endmodule : cwv_host

// *** sim/tb.sv ***
// Self-checking bench for the verb register block
`timescale 1ns/1ps
module tb;
	import cwv_pkg::*;
	localparam logic [7:0] M = NODE_MIC1;
	localparam logic [7:0] S = NODE_SEL0;
	logic        clk, sys_rst, link_clk, link_rst, digital_microphone;
	logic        verb_valid, resp_valid, ipe, jdo;
	logic [7:0]  verb_node, verb_payload;
	logic [11:0] verb_id;
	logic [31:0] resp_data;
	logic [2:0]  gr, gl, src;
	int          err_total, tests_run;
	cwv_regs DUT (.clk(clk), .sys_rst(sys_rst), .link_clk(link_clk), .link_rst(link_rst),
		.verb_valid(verb_valid), .verb_node(verb_node), .verb_id(verb_id),
		.verb_payload(verb_payload), .resp_valid(resp_valid), .resp_data(resp_data),
		.digital_microphone_enable(digital_microphone), .input_path_enable(ipe),
		.jack_detect_override(jdo), .right_output_gain(gr), .left_output_gain(gl),
		.source_choice(src));
	cwv_host host (.verb_valid(verb_valid), .verb_node(verb_node), .verb_id(verb_id),
		.verb_payload(verb_payload), .link_clk(link_clk), .resp_valid(resp_valid),
		.resp_data(resp_data));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Link clock offset so its edges never line up with the core clock
	initial begin
		link_clk = 1'b0;
		#7;
		forever #32 link_clk = ~link_clk;
	end
	// ==========================================================
	// Comparison, verdict and transfer helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("checks=%0d mismatches=%0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	task automatic vb(input logic [7:0] n, input logic [11:0] id, input logic [7:0] p,
		input logic [31:0] exp, input int idle = 0);
		logic [31:0] r;
		bit ok;
		host.xfer(n, id, p, idle, r, ok);
		if (!ok) begin
			err_total++;
			tally_and_finish();
		end else
			check(r, exp);
	endtask : vb
	// ==========================================================
	// Scenarios
	task automatic t_reset;
		check({24'h0, ipe, jdo, gr, gl}, 32'h0);
		check({29'h0, src}, 32'h0);
		vb(M, VERB_GET_DEF, 8'h00, 32'h50A0_00F0);
		vb(M, VERB_GET_CTL, 8'h00, 32'h0000_0000);
		vb(S, VERB_GET_GAIN_R, 8'h00, 32'h0000_0000, 3);
		vb(S, VERB_GET_SRC, 8'h00, 32'h0000_0000);
	endtask : t_reset
	task automatic t_caps;
		logic [11:0] id[5] = '{VERB_GET_PARAM, VERB_GET_PARAM, VERB_GET_PARAM,
			VERB_GET_LIST, VERB_GET_LIST};
		logic [7:0]  pa[5] = '{8'h09, 8'h12, 8'h0E, 8'h00, 8'h04};
		logic [31:0] ex[5] = '{32'h0030_010D, 32'h0027_0400, 32'h0000_0007,
			32'h0B0F_160E, 32'h000A_0D0C};
		@(negedge clk);
		digital_microphone = 1'b0;
		repeat (4) @(negedge clk);
		vb(M, VERB_GET_PARAM, 8'h09, 32'h00F0_0001);
		@(negedge clk);
		digital_microphone = 1'b1;
		repeat (4) @(negedge clk);
		vb(M, VERB_GET_PARAM, 8'h09, 32'h0040_0001);
		vb(M, VERB_GET_PARAM, 8'h0C, 32'h0000_0020);
		for (int k = 0; k < 5; k++)
			vb(S, id[k], pa[k], ex[k]);
		vb(8'h1A, VERB_GET_PARAM, 8'h09, 32'h0000_0000);
		vb(S, VERB_GET_CTL, 8'h00, 32'h0000_0000);
	endtask : t_caps
	task automatic t_ctl;
		vb(M, VERB_SET_CTL, 8'hFF, 32'h0000_0000);
		vb(M, VERB_GET_CTL, 8'h00, 32'h0000_0020);
		check({31'h0, ipe}, 32'h1);
		vb(M, VERB_SET_CTL, 8'hDF, 32'h0000_0000);
		vb(M, VERB_GET_CTL, 8'h00, 32'h0000_0000);
		check({31'h0, ipe}, 32'h0);
		vb(S, VERB_SET_CTL, 8'hFF, 32'h0000_0000);
		check({31'h0, ipe}, 32'h0);
	endtask : t_ctl
	task automatic t_def;
		logic [1:0]  by[5] = '{2'd0, 2'd1, 2'd2, 2'd3, 2'd1};
		logic [7:0]  pa[5] = '{8'h3E, 8'h01, 8'h5B, 8'h92, 8'hFE};
		logic [31:0] ex[5] = '{32'h50A0_003E, 32'h50A0_013E, 32'h505B_013E,
			32'h925B_013E, 32'h925B_FE3E};
		// Grouping kept nonzero, order unique within it
		for (int k = 0; k < 5; k++) begin
			vb(M, VERB_SET_DEF0 + 12'(by[k]), pa[k], 32'h0000_0000);
			vb(M, VERB_GET_DEF, 8'h00, ex[k]);
			check({31'h0, jdo}, {31'h0, ex[k][8]});
		end
	endtask : t_def
	task automatic t_gain;
		vb(S, VERB_SET_GAIN_R, 8'hFC, 32'h0000_0000);
		check({26'h0, gr, gl}, {26'h0, 3'h4, 3'h0});
		vb(S, VERB_SET_GAIN_L, 8'h0B, 32'h0000_0000, 2);
		vb(8'h1A, VERB_SET_GAIN_R, 8'h01, 32'h0000_0000);
		vb(M, VERB_SET_GAIN_L, 8'h02, 32'h0000_0000);
		vb(S, VERB_GET_GAIN_R, 8'h00, 32'h0000_0004);
		vb(S, VERB_GET_GAIN_L, 8'h00, 32'h0000_0003);
		check({26'h0, gr, gl}, {26'h0, 3'h4, 3'h3});
	endtask : t_gain
	task automatic t_src;
		vb(S, VERB_SET_SRC, 8'hF9, 32'h0000_0000);
		vb(S, VERB_GET_SRC, 8'h00, 32'h0000_0001);
		check({29'h0, src}, 32'h1);
		vb(S, VERB_SET_SRC, 8'h07, 32'h0000_0000);
		vb(S, VERB_GET_SRC, 8'h00, 32'h0000_0007);
	endtask : t_src
	// ==========================================================
	// Main sequence
	initial begin
		err_total = 0;
		tests_run = 0;
		digital_microphone = 1'b0;
		sys_rst = 1'b1;
		link_rst = 1'b1;
		repeat (10) @(negedge clk);
		sys_rst = 1'b0;
		repeat (3) @(negedge link_clk);
		link_rst = 1'b0;
		repeat (3) @(negedge clk);
		t_reset();
		t_caps();
		t_ctl();
		t_def();
		t_gain();
		t_src();
		tally_and_finish();
	end
endmodule : tb
